// ==== sram_boundary_scan_tap_tb_top.sv ====
// bench: tester and memory test port joined by the link, driven over apb
// assumes the tester half period is 7 pclk cycles of 4 ns
`timescale 1ns/1ps
module sram_boundary_scan_tap_tb_top;
    import srbst_pkg::*;
    localparam logic [10:0]      MFR = 11'h155;          // arbitrary maker code
    localparam logic [BSR_W-1:0] NC  = 107'h1 << 47;     // one unconnected cell
    localparam logic [31:0]      IDW = {3'h0, 2'h0, 3'h1, 1'h0, 2'h3, 1'h0, 1'h1, 1'h0,
                                        1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, MFR, 1'h1};
    logic             pclk, presetn, psel, penable, pwrite;  // apb side
    logic [7:0]       paddr;
    logic [31:0]      pwdata, prdata, r;
    logic             pready, pslverr, e;
    logic [BSR_W-1:0] pad_in;                                 // pad levels
    logic             dq_hiz, tap_reset;
    logic [127:0]     d;                                      // captured scan data
    logic [31:0]      c;
    // only defined codes are ever loaded
    logic [2:0]       codes [3] = '{INS_EXTEST, INS_SAMPLE_Z, INS_SAMPLE};
    int               n_mismatch, comparisons, cycles, i;

    srbst_if link ();
    srbst_host #(.HALF(7)) srbst_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .jtag(link));
    srbst_tap #(.ID_MFR(MFR), .NC_MASK(NC)) srbst_tap_i (.pclk(pclk),
        .presetn(presetn), .pad_in(pad_in), .dq_hiz(dq_hiz), .tap_reset(tap_reset),
        .jtag(link));
    srbst_properties srbst_properties_i (.pclk(pclk), .presetn(presetn), .tck(link.tck),
        .tms(link.tms), .tdo_out(link.tdo_out), .tdo_oe_n(link.tdo_oe_n),
        .tap_reset(tap_reset), .dq_hiz(dq_hiz));

    // 250 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // a hang is cut short well above the expected run length
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_mismatch = n_mismatch + 1;
            finish_test();
        end
    end

    // case-equal compare, so an unknown never matches
    task automatic check(input logic [127:0] got, input logic [127:0] exp, input string what);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask

    // one apb transfer; held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // one tester order of n bits; returns the n tdo captures, first in bit 0
    task automatic run(input int n, input logic [31:0] ms, input logic [31:0] di,
                       output logic [31:0] cap);
        logic [31:0] rv;
        logic        ev;
        xfer(1'b1, REG_TMS, ms, rv, ev);
        xfer(1'b1, REG_TDI, di, rv, ev);
        xfer(1'b1, REG_CTRL, (32'(n - 1) << CTRL_LEN_LSB) | 32'h1, rv, ev);
        // poll busy; the bench timeout bounds this wait
        do xfer(1'b0, REG_STATUS, 32'h0, rv, ev); while (rv[0] === 1'b1);
        xfer(1'b0, REG_TDO, 32'h0, rv, ev);
        cap = rv >> (32 - n);
    endtask

    // idle to shift-dr, nb bits with exit on the last, then update and idle
    task automatic scan_dr(input int nb, input logic [127:0] din, output logic [127:0] dout);
        logic [31:0] cv;
        int          k;
        int          len;
        dout = '0;
        run(3, 32'h1, 32'h0, cv);
        for (k = 0; k < nb; k += 32) begin
            len = (nb - k > 32) ? 32 : nb - k;
            run(len, (k + len == nb) ? 32'h1 << (len - 1) : 32'h0, din[k+:32], cv);
            dout[k+:32] = cv;
        end
        run(2, 32'h1, 32'h0, cv);
    endtask

    // idle to shift-ir, three code bits lsb first, update, back to idle
    task automatic load_ir(input logic [2:0] code);
        logic [31:0] cv;
        run(9, 32'h0c3, 32'(code) << 4, cv);
        check(cv[6:4], IR_CAPTURE, "ir capture pattern");
    endtask

    // verdict and end of run
    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pad_in = '0;
        presetn = 1'b0;
        n_mismatch = 0;
        comparisons = 0;
        cycles = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(tap_reset, 1'b1, "port not in reset state");
        check(dq_hiz, 1'b0, "data pins high-z after reset");
        check(link.tdo_oe_n, 1'b1, "tdo driven after reset");
        check(link.tdo, 1'b1, "tdo line not left floating");
        xfer(1'b0, REG_STATUS, 32'h0, r, e);
        check(r, 32'h0, "status after reset");
        check(link.tck, 1'b0, "tck not resting low");
        xfer(1'b0, 8'h14, 32'h0, r, e);
        check({e, r}, 33'h1_0000_0000, "unmapped read");
        run(1, 32'h0, 32'h0, c);
        check(tap_reset, 1'b0, "port stayed in reset");
        // default instruction reads the id word, then passes tdi through
        scan_dr(64, {64'h0, 32'hc3a5_0f96}, d);
        check(d[31:0], IDW, "id word");
        check(d[63:32], 32'hc3a5_0f96, "id chain pass-through");
        // boundary instructions: high-z per code, pads captured
        for (i = 0; i < 3; i++) begin
            pad_in <= 107'(128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210 << i);
            load_ir(codes[i]);
            check(dq_hiz, (i < 2), "data pin high-z");
            scan_dr(BSR_W, 128'h0, d);
            check(d[BSR_W-1:0], pad_in & ~NC, "boundary capture");
        end
        // bypass: cleared first, then one stage delay
        load_ir(INS_BYPASS);
        check(dq_hiz, 1'b0, "bypass high-z");
        scan_dr(4, 128'hb, d);
        check(d[3:0], 4'h6, "bypass data");
        // five tms ones restore the id instruction
        run(5, 32'h1f, 32'h0, c);
        check(tap_reset, 1'b1, "tms ones reset");
        run(1, 32'h0, 32'h0, c);
        scan_dr(32, 128'h0, d);
        check(d[31:0], IDW, "id after tms reset");
        finish_test();
    end
endmodule

// ==== srbst_host.sv ====
// tester end: shifts up to 32 tms/tdi bits per order and records tdo
// assumes software on apb loads tms and tdi, then writes the bit count in the same ctrl write as start
`timescale 1ns/1ps
module srbst_host
    import srbst_pkg::*;
#(
    parameter int HALF = TCK_HALF_CYC  // pclk cycles per tck phase
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    srbst_if.host            jtag
);
    import srbst_pkg::*;

    // tdo crosses two three-flop paths before the host sees it, so a phase
    // shorter than five cycles would sample the answer before it settles
    if (HALF < 5 || HALF > 255) begin : g_half_check
        $error("HALF out of range");
    end

    srbst_host_e      state;     // sequencer state
    logic [31:0]      tms_seq;   // tms bits, lsb goes first
    logic [31:0]      tdi_seq;   // tdi bits, lsb goes first
    logic [31:0]      tdo_cap;   // captured tdo, newest bit at msb
    logic [LEN_W-1:0] left;      // bits still to send after this one
    logic [7:0]       cnt;       // pclk count within a phase
    logic [SYNC_N-1:0] tdo_s;    // tdo synchroniser
    logic             tdo_f;     // filtered tdo
    logic             acc;       // apb access phase
    logic             busy;

    assign acc  = psel & penable;
    assign busy = (state != HS_IDLE);

    // tdo passes three flops; a change counts once the last two agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tdo_s <= '1;
            tdo_f <= 1'b1;
        end else begin
            tdo_s <= {tdo_s[SYNC_N-2:0], jtag.tdo};
            if (tdo_s[SYNC_N-1] == tdo_s[SYNC_N-2]) tdo_f <= tdo_s[SYNC_N-1];
        end
    end

    // apb answers in the first access cycle; unmapped offsets flag an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= SEQ_RESET;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            prdata  <= SEQ_RESET;
            if (psel && !penable) begin
                case (paddr)
                    REG_CTRL:   prdata <= SEQ_RESET;
                    REG_TMS:    prdata <= tms_seq;
                    REG_TDI:    prdata <= tdi_seq;
                    REG_TDO:    prdata <= tdo_cap;
                    REG_STATUS: prdata <= {31'h0, busy};
                    default:    pslverr <= 1'b1;
                endcase
            end
        end
    end

    // bit sequencer and tck divider; tck rests low when idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state         <= HS_IDLE;
            tms_seq       <= SEQ_RESET;
            tdi_seq       <= SEQ_RESET;
            tdo_cap       <= SEQ_RESET;
            left          <= '0;
            cnt           <= '0;
            jtag.tck      <= 1'b0;
            jtag.tms_out  <= 1'b1;
            jtag.tdi_out  <= 1'b1;
            jtag.tms_oe_n <= 1'b1;
            jtag.tdi_oe_n <= 1'b1;
        end else begin
            jtag.tms_oe_n <= 1'b0;
            jtag.tdi_oe_n <= 1'b0;
            case (state)
                HS_IDLE: begin
                    jtag.tck <= 1'b0;
                    // writes are ignored while a sequence runs
                    if (acc && pready && pwrite && paddr == REG_TMS) tms_seq <= pwdata;
                    if (acc && pready && pwrite && paddr == REG_TDI) tdi_seq <= pwdata;
                    if (acc && pready && pwrite && paddr == REG_CTRL && pwdata[CTRL_START]) begin
                        left         <= pwdata[CTRL_LEN_LSB +: LEN_W];
                        jtag.tms_out <= tms_seq[0];
                        jtag.tdi_out <= tdi_seq[0];
                        cnt          <= '0;
                        state        <= HS_LOW;
                    end
                end
                HS_LOW: begin
                    cnt <= cnt + 8'h01;
                    if (cnt == 8'(HALF - 1)) begin
                        jtag.tck <= 1'b1;
                        cnt      <= '0;
                        state    <= HS_HIGH;
                    end
                end
                HS_HIGH: begin
                    cnt <= cnt + 8'h01;
                    if (cnt == 8'(HALF - 1)) begin
                        // tdo taken at the end of the high phase
                        // the bit seen at the rise still stands here, and the
                        // device's next change is only launched after this fall
                        tdo_cap  <= {tdo_f, tdo_cap[31:1]};
                        jtag.tck <= 1'b0;
                        cnt      <= '0;
                        tms_seq  <= {1'b1, tms_seq[31:1]};
                        tdi_seq  <= {1'b1, tdi_seq[31:1]};
                        if (left == '0) begin
                            state <= HS_IDLE;
                        end else begin
                            left         <= left - 1'b1;
                            jtag.tms_out <= tms_seq[1];
                            jtag.tdi_out <= tdi_seq[1];
                            state        <= HS_LOW;
                        end
                    end
                end
                default: state <= HS_IDLE;
            endcase
        end
    end
endmodule

// ==== srbst_if.sv ====
// link between the tester and the memory test port: tck, tms, tdi, tdo
// assumes both ends are design modules joined by the bench; pins resolve here
`timescale 1ns/1ps
interface srbst_if;
    logic tck;        // test clock, made by the tester
    logic tms_out;    // mode select as driven
    logic tms_oe_n;   // low while tms is driven
    logic tdi_out;    // serial data in as driven
    logic tdi_oe_n;   // low while tdi is driven
    logic tdo_out;    // serial data out as driven
    logic tdo_oe_n;   // low while tdo is driven
    logic tms;        // resolved levels
    logic tdi;
    logic tdo;
    // an undriven pin floats to one, as an internal pull-up would
    assign tms = tms_oe_n ? 1'b1 : tms_out;
    assign tdi = tdi_oe_n ? 1'b1 : tdi_out;
    assign tdo = tdo_oe_n ? 1'b1 : tdo_out;
    modport device (input tck, input tms, input tdi, output tdo_out, output tdo_oe_n);
    modport host (output tck, output tms_out, output tms_oe_n, output tdi_out,
                  output tdi_oe_n, input tdo);
endinterface

// ==== srbst_pkg.sv ====
// shared constants for the memory boundary-scan test port and its tester
// assumes both ends run on one pclk of 250 MHz and meet through srbst_if
package srbst_pkg;
    // scan register sizes
    localparam int IR_W  = 3;
    localparam int ID_W  = 32;
    localparam int BSR_W = 107;
    // instruction codes, msb (instr_code_msb) first down to instr_code_lsb
    localparam logic [2:0] INS_EXTEST   = 3'h0;
    localparam logic [2:0] INS_IDCODE   = 3'h1;
    localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
    localparam logic [2:0] INS_SAMPLE   = 3'h4;
    localparam logic [2:0] INS_BYPASS   = 3'h7;
    // value after reset of the instruction register, and its capture pattern
    localparam logic [2:0] IR_RESET     = INS_IDCODE;
    localparam logic [2:0] IR_CAPTURE   = 3'h1;
    // identification word field positions
    localparam int ID_REV_LSB = 29;
    localparam int ID_CFG_LSB = 12;
    localparam int ID_MFR_LSB = 1;
    // input synchroniser depth
    localparam int SYNC_N = 3;
    // link clock timing: least tck half period and pclk period
    localparam int PCLK_PS      = 4000;
    localparam int TCK_HALF_PS  = 25000;
    localparam int TCK_HALF_CYC = (TCK_HALF_PS + PCLK_PS - 1) / PCLK_PS;
    // tester register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_TMS    = 8'h04;
    localparam logic [7:0] REG_TDI    = 8'h08;
    localparam logic [7:0] REG_TDO    = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    // ctrl fields: start bit and bit-count field (count minus one)
    localparam int CTRL_START   = 0;
    localparam int CTRL_LEN_LSB = 8;
    localparam int LEN_W        = 5;
    // tester register values after reset
    localparam logic [31:0] SEQ_RESET = 32'h0000_0000;
    // tap controller states, one-hot
    typedef enum logic [15:0] {
        ST_TLR  = 16'h0001, ST_RTI  = 16'h0002, ST_SDRS = 16'h0004,
        ST_CDR  = 16'h0008, ST_SDR  = 16'h0010, ST_E1DR = 16'h0020,
        ST_PDR  = 16'h0040, ST_E2DR = 16'h0080, ST_UDR  = 16'h0100,
        ST_SIRS = 16'h0200, ST_CIR  = 16'h0400, ST_SIR  = 16'h0800,
        ST_E1IR = 16'h1000, ST_PIR  = 16'h2000, ST_E2IR = 16'h4000,
        ST_UIR  = 16'h8000
    } srbst_tap_e;
    // tester sequencer states, one-hot
    typedef enum logic [2:0] {
        HS_IDLE = 3'h1, HS_LOW = 3'h2, HS_HIGH = 3'h4
    } srbst_host_e;
endpackage

// ==== srbst_properties.sv ====
// concurrent checks on the tap link and on the test port's status flags
// assumes the tester holds each tck phase for 7 pclk cycles
`timescale 1ns/1ps
module srbst_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdo_out,
    input wire logic tdo_oe_n,
    input wire logic tap_reset,
    input wire logic dq_hiz
);
    logic       tck_q;    // tck one pclk earlier
    logic       rise;     // tck rose at this edge
    logic       last_tms; // tms seen at the latest tck rise
    logic [2:0] ones;     // run of tms ones at tck rises, saturating

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    assign rise = tck & ~tck_q;

    // edge detector on the tester's clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) tck_q <= 1'b0;
        else tck_q <= tck;
    end

    // tms history, kept only at tck rises since the port moves only there
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_tms <= 1'b1;
            ones     <= 3'h0;
        end else if (rise) begin
            last_tms <= tms;
            ones     <= !tms ? 3'h0 : (ones == 3'h5) ? 3'h5 : ones + 3'h1;
        end
    end

    AST_TDO_OFF_IN_RESET: assert property (tap_reset |-> tdo_oe_n)
        else $error("tdo driven in reset state");
    AST_TDO_MOVES_TCK_LOW: assert property
        (($changed(tdo_out) || $changed(tdo_oe_n)) |-> !tck)
        else $error("tdo changed while tck high");
    AST_TCK_HIGH_PHASE: assert property ($rose(tck) |=> tck [*5])
        else $error("tck high phase too short");
    AST_TCK_LOW_PHASE: assert property ($fell(tck) |=> !tck [*5])
        else $error("tck low phase too short");
    AST_FIVE_ONES_RESET: assert property
        (rise && tms && ones == 3'h4 |-> ##[1:14] tap_reset)
        else $error("five tms ones did not reset the port");
    AST_LEAVE_RESET: assert property
        (rise && !tms && tap_reset |-> ##[1:14] !tap_reset)
        else $error("tms zero did not leave reset state");
    AST_NO_HIZ_IN_RESET: assert property (tap_reset [*3] |-> !dq_hiz)
        else $error("data pins high-z in reset state");
    AST_DRIVE_ON_TMS_LOW: assert property ($fell(tdo_oe_n) |-> !last_tms)
        else $error("tdo driven without entering shift");
    AST_RELEASE_ON_TMS_HIGH: assert property ($rose(tdo_oe_n) |-> last_tms)
        else $error("tdo released without leaving shift");

    // main scenarios reached
    cover property ($rose(dq_hiz));
    cover property ($fell(tdo_oe_n));
    cover property ($fell(tap_reset));
endmodule

// ==== srbst_tap.sv ====
// memory boundary-scan test port: tap controller and its scan registers
// assumes tck, tms, tdi and the pad levels come from outside the pclk domain
`timescale 1ns/1ps
module srbst_tap
    import srbst_pkg::*;
#(
    parameter logic [2:0]       ID_REV  = 3'h0,        // revision field
    parameter logic [2:0]       CFG_DEN = 3'h1,        // density code
    parameter logic [1:0]       CFG_WID = 2'h3,        // data width code
    parameter logic             CFG_DLL = 1'b1,        // dll present
    parameter logic             CFG_QDR = 1'b0,        // quad rate
    parameter logic             CFG_B4  = 1'b0,        // four-beat burst
    parameter logic             CFG_SIO = 1'b0,        // separate io
    parameter logic [10:0]      ID_MFR  = 11'h2a5,     // arbitrary maker code
    parameter logic [BSR_W-1:0] NC_MASK = '0           // unconnected cells
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [BSR_W-1:0] pad_in,    // pad levels, cell 0 nearest tdo
    output logic                  dq_hiz,    // data pins forced to high-z
    output logic                  tap_reset, // controller in test-logic-reset
    srbst_if.device               jtag
);
    import srbst_pkg::*;

    localparam logic [ID_W-1:0] ID_WORD = {ID_REV, 2'b00, CFG_DEN, 1'b0, CFG_WID,
        1'b0, CFG_DLL, 1'b0, CFG_QDR, 1'b0, CFG_B4, 1'b0, CFG_SIO, 1'b0, ID_MFR, 1'b1};

    srbst_tap_e        state;        // controller state
    srbst_tap_e        next_state;
    logic [SYNC_N-1:0] tck_s;        // synchronisers
    logic [SYNC_N-1:0] tms_s;
    logic [SYNC_N-1:0] tdi_s;
    logic              tck_f;        // filtered levels
    logic              tms_f;
    logic              tdi_f;
    logic              tck_d;        // tck one cycle back, for edges
    logic              rise;
    logic              fall;
    logic [BSR_W-1:0]  pad_s1;       // pad synchroniser
    logic [BSR_W-1:0]  pad_s2;
    logic [BSR_W-1:0]  pad_s3;
    logic [BSR_W-1:0]  pad_f;
    logic [IR_W-1:0]   ir;           // active instruction
    logic [IR_W-1:0]   ir_sh;        // instruction shift stage
    logic [ID_W-1:0]   id_sh;        // identification chain
    logic [BSR_W-1:0]  bsr;          // boundary chain
    logic              byp;          // bypass cell
    logic              sel_bsr;      // data chain selection
    logic              sel_id;
    logic              dr_out;       // bit the selected chain presents

    assign rise = tck_f & ~tck_d;
    assign fall = ~tck_f & tck_d;

    // boundary for extest and both samples, id for idcode
    assign sel_bsr = (ir == INS_EXTEST) || (ir == INS_SAMPLE_Z) || (ir == INS_SAMPLE);
    assign sel_id  = (ir == INS_IDCODE);
    // reserved codes fall to the bypass cell, which is as harmless as any
    assign dr_out  = sel_bsr ? bsr[0] : (sel_id ? id_sh[0] : byp);

    // pins pass three flops; a change counts once the last two agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tck_s <= '0;
            tms_s <= '1;
            tdi_s <= '1;
            tck_f <= 1'b0;
            tms_f <= 1'b1;
            tdi_f <= 1'b1;
            tck_d <= 1'b0;
        end else begin
            tck_s <= {tck_s[SYNC_N-2:0], jtag.tck};
            tms_s <= {tms_s[SYNC_N-2:0], jtag.tms};
            tdi_s <= {tdi_s[SYNC_N-2:0], jtag.tdi};
            if (tck_s[SYNC_N-1] == tck_s[SYNC_N-2]) tck_f <= tck_s[SYNC_N-1];
            // undriven pins already read as one at the wire
            if (tms_s[SYNC_N-1] == tms_s[SYNC_N-2]) tms_f <= tms_s[SYNC_N-1];
            if (tdi_s[SYNC_N-1] == tdi_s[SYNC_N-2]) tdi_f <= tdi_s[SYNC_N-1];
            tck_d <= tck_f;
        end
    end

    // pad levels take the same path so they line up with tck
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_s1 <= '0;
            pad_s2 <= '0;
            pad_s3 <= '0;
            pad_f  <= '0;
        end else begin
            pad_s1 <= pad_in;
            pad_s2 <= pad_s1;
            pad_s3 <= pad_s2;
            pad_f  <= (pad_s3 & ~(pad_s2 ^ pad_s3)) | (pad_f & (pad_s2 ^ pad_s3));
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_TLR:  next_state = tms_f ? ST_TLR  : ST_RTI;
            ST_RTI:  next_state = tms_f ? ST_SDRS : ST_RTI;
            ST_SDRS: next_state = tms_f ? ST_SIRS : ST_CDR;
            ST_CDR:  next_state = tms_f ? ST_E1DR : ST_SDR;
            ST_SDR:  next_state = tms_f ? ST_E1DR : ST_SDR;
            ST_E1DR: next_state = tms_f ? ST_UDR  : ST_PDR;
            ST_PDR:  next_state = tms_f ? ST_E2DR : ST_PDR;
            ST_E2DR: next_state = tms_f ? ST_UDR  : ST_SDR;
            ST_UDR:  next_state = tms_f ? ST_SDRS : ST_RTI;
            ST_SIRS: next_state = tms_f ? ST_TLR  : ST_CIR;
            ST_CIR:  next_state = tms_f ? ST_E1IR : ST_SIR;
            ST_SIR:  next_state = tms_f ? ST_E1IR : ST_SIR;
            ST_E1IR: next_state = tms_f ? ST_UIR  : ST_PIR;
            ST_PIR:  next_state = tms_f ? ST_E2IR : ST_PIR;
            ST_E2IR: next_state = tms_f ? ST_UIR  : ST_SIR;
            ST_UIR:  next_state = tms_f ? ST_SDRS : ST_RTI;
            default: next_state = ST_TLR;
        endcase
    end

    // power-up reset lands in test-logic-reset; moves on tck rise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_TLR;
        end else if (rise) begin
            state <= next_state;
        end
    end

    // instruction path: capture and shift on rise, update on fall
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ir_sh <= IR_CAPTURE;
            ir    <= IR_RESET;
        end else if (state == ST_TLR) begin
            ir <= IR_RESET;
        end else if (rise && state == ST_CIR) begin
            ir_sh <= IR_CAPTURE;
        end else if (rise && state == ST_SIR) begin
            ir_sh <= {tdi_f, ir_sh[IR_W-1:1]};
        end else if (fall && state == ST_UIR) begin
            ir <= ir_sh;
        end
    end

    // data chains: capture and shift on tck rise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bsr   <= '0;
            id_sh <= ID_WORD;
            byp   <= 1'b0;
        end else if (rise && state == ST_CDR) begin
            // pads taken, unconnected cells read zero
            if (sel_bsr) bsr <= pad_f & ~NC_MASK;
            if (sel_id) id_sh <= ID_WORD;
            byp <= 1'b0;
        end else if (rise && state == ST_SDR) begin
            // tdi enters the chain's far end
            if (sel_bsr) bsr <= {tdi_f, bsr[BSR_W-1:1]};
            if (sel_id) id_sh <= {tdi_f, id_sh[ID_W-1:1]};
            // holds last tdi bit on exit
            if (!sel_bsr && !sel_id) byp <= tdi_f;
        end
    end

    // tdo moves after tck falls, driven only in shift states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            jtag.tdo_out  <= 1'b0;
            jtag.tdo_oe_n <= 1'b1;
        end else if (fall) begin
            jtag.tdo_out  <= (state == ST_SIR) ? ir_sh[0] : dr_out;
            jtag.tdo_oe_n <= !(state == ST_SIR || state == ST_SDR);
        end
    end

    // data pins held high-z under extest and sample-z
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dq_hiz    <= 1'b0;
            tap_reset <= 1'b1;
        end else begin
            dq_hiz    <= (ir == INS_EXTEST) || (ir == INS_SAMPLE_Z);
            tap_reset <= (state == ST_TLR);
        end
    end
endmodule
